// File: core/dram_mode_pkg.sv
// Behaviour
// - format_revision bits always read back zero.
// - init_done_flag is plain read-write software state.
// - idle precharged row pair enters power-down.
// - access wakes its row pair before proceeding.
// - CKE low enters, high exits power-down.
// - retry enabled: one reissue after double-bit error.
// - overlap bit permits activates during column command.
// - write auto-precharge code: smart, always, never.
// - read auto-precharge code: smart, always, never.
// - integrity code: none, 72-bit, chip-fail ECC.
// - non-ECC mode: no correction, nothing logged.
// - chip-fail in single channel falls to 72-bit.
package dram_mode_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] MODE_OFFSET = 8'h7C;
    localparam logic [7:0] STATUS_OFFSET = 8'h90;
    localparam logic [7:0] MASK_OFFSET = 8'h94;
    localparam logic [7:0] CKE_OFFSET = 8'h98;
    localparam logic [31:0] MODE_RESET = 32'h00000008;
    localparam logic [31:0] MODE_WR_MASK = 32'h3FF007FF;
    localparam logic [31:0] ZERO_WORD = 32'h00000000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Mode register fields
    // ------------------------------------------------------------
    localparam int REV_LSB = 30;
    localparam int INIT_BIT = 29;
    localparam int PD_BIT = 28;
    localparam int RETRY_BIT = 27;
    localparam int OVERLAP_BIT = 26;
    localparam int WR_AP_LSB = 24;
    localparam int RD_AP_LSB = 22;
    localparam int INTEG_LSB = 20;

    // ------------------------------------------------------------
    // Interrupt status bits
    // ------------------------------------------------------------
    localparam int EV_FATAL = 0;
    localparam int EV_RETRY = 1;
    localparam int EV_LOG = 2;
    localparam int EV_WIDTH = 3;
    localparam logic [EV_WIDTH-1:0] EV_RESET = 3'h0;

    typedef enum logic [1:0] {
        AP_SMART = 2'h0,
        AP_ALWAYS = 2'h1,
        AP_NEVER = 2'h2,
        AP_RSVD = 2'h3
    } ap_mode_type;

    typedef enum logic [1:0] {
        INTEG_NONE = 2'h0,
        INTEG_ECC72 = 2'h1,
        INTEG_CHIPFAIL = 2'h2,
        INTEG_RSVD = 2'h3
    } integ_mode_type;

    // Reserved policy code behaves as never, which is the conservative choice.
    function automatic logic ap_close(input logic [1:0] code, input logic row_hit_queued);
        return (code == AP_ALWAYS) || ((code == AP_SMART) && !row_hit_queued);
    endfunction

endpackage

// File: core/cke_pair_ctl.sv
`timescale 1ns/1ps
module cke_pair_ctl
    import dram_mode_pkg::*;
#(
    parameter int BANKS = 4
) (
    input wire logic aclk, // controller clock
    input wire logic aresetn, // synchronous reset, active low
    input wire logic ce, // clock enable
    input wire logic pd_en, // dynamic power-down enabled
    input wire logic [BANKS-1:0] bank_open, // open state of each bank of the pair
    input wire logic req, // access waiting for this pair
    output logic cke_q, // clock enable to the rows
    output logic grant_q // access may proceed, one cycle after each cycle req is seen awake
);

    wire all_closed = ~|bank_open;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cke_q <= 1'b1;
            grant_q <= 1'b0;
        end else if (ce) begin
            grant_q <= req && cke_q;
            if (req || !pd_en) begin
                cke_q <= 1'b1;
            end else if (all_closed) begin
                cke_q <= 1'b0;
            end
        end
    end

endmodule

// File: core/ecc_mode_ctl.sv
`timescale 1ns/1ps
module ecc_mode_ctl
    import dram_mode_pkg::*;
(
    input wire logic aclk, // controller clock
    input wire logic aresetn, // synchronous reset, active low
    input wire logic ce, // clock enable
    input wire logic [1:0] mode_code, // programmed integrity_mode_select
    input wire logic single_channel, // controller runs one channel
    input wire logic err_seen, // ECC error detected on a read
    input wire logic first_pending, // a first error is already held
    output integ_mode_type eff_mode_q, // integrity mode in force
    output logic corr_en_q, // error correction active
    output logic log_first_q, // write first_error_log, one cycle
    output logic log_next_q // write next_error_log, one cycle
);

    integ_mode_type eff_d;

    // Reserved code is treated as no ECC so nothing is corrected by guess.
    assign eff_d = (mode_code == INTEG_CHIPFAIL && single_channel) ? INTEG_ECC72 :
                   (mode_code == INTEG_RSVD) ? INTEG_NONE : integ_mode_type'(mode_code);

    wire log_ok = err_seen && (eff_mode_q != INTEG_NONE);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            eff_mode_q <= INTEG_NONE;
            corr_en_q <= 1'b0;
            log_first_q <= 1'b0;
            log_next_q <= 1'b0;
        end else if (ce) begin
            eff_mode_q <= eff_d;
            corr_en_q <= eff_d != INTEG_NONE;
            log_first_q <= log_ok && !first_pending;
            log_next_q <= log_ok && first_pending;
        end
    end

endmodule

// File: core/dram_mode_ctl.sv
`timescale 1ns/1ps
module dram_mode_ctl
    import dram_mode_pkg::*;
#(
    parameter int ROW_PAIRS = 4,
    parameter int BANKS = 4,
    parameter int PAIR_W = 2
) (
    input wire logic aclk, // controller clock, 200 MHz
    input wire logic aresetn, // synchronous reset, active low
    input wire logic ce, // clock enable, freezes all state when low
    // AXI4-Lite slave
    input wire logic [7:0] s_awaddr, // write address
    input wire logic s_awvalid, // write address valid
    output logic s_awready, // write address ready
    input wire logic [31:0] s_wdata, // write data
    input wire logic [3:0] s_wstrb, // write byte strobes
    input wire logic s_wvalid, // write data valid
    output logic s_wready, // write data ready
    output logic [1:0] s_bresp, // write response
    output logic s_bvalid, // write response valid
    input wire logic s_bready, // write response ready
    input wire logic [7:0] s_araddr, // read address
    input wire logic s_arvalid, // read address valid
    output logic s_arready, // read address ready
    output logic [31:0] s_rdata, // read data
    output logic [1:0] s_rresp, // read response
    output logic s_rvalid, // read data valid
    input wire logic s_rready, // read data ready
    output logic irq, // level interrupt
    // Row pair power-down
    input wire logic [ROW_PAIRS*BANKS-1:0] bank_open, // open state per bank
    input wire logic acc_valid, // access request, held until granted
    input wire logic [PAIR_W-1:0] acc_pair, // row pair of the access
    output logic [ROW_PAIRS-1:0] cke, // clock enable per row pair
    output logic acc_grant, // access may proceed, one cycle after each cycle acc_valid is seen with its pair awake
    // Read retry and ECC
    input wire logic single_channel, // controller runs one channel
    input wire logic rd_done, // read data checked, one cycle
    input wire logic rd_sbe, // single-bit error on that read
    input wire logic rd_ded, // double-bit error on that read
    input wire logic rd_was_retry, // that read was already a retry
    output logic retry_req, // reissue the read, one cycle
    output logic corr_en, // correction active
    output integ_mode_type integ_mode, // integrity mode in force
    output logic log_first, // record in first_error_log
    output logic log_next, // record in next_error_log
    // Scheduling policy
    input wire logic col_busy, // column command outstanding
    output logic act_allowed, // an activate may issue now
    input wire logic col_valid, // column command being scheduled
    input wire logic col_is_write, // it is a write
    input wire logic row_hit_queued, // a queued request hits the same row
    output logic ap_flag, // issue that command with auto-precharge
    output logic init_done_flag // software marked the interface ready
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [31:0] mode_q;
    logic [EV_WIDTH-1:0] status_q;
    logic [EV_WIDTH-1:0] mask_q;
    logic aw_have_q;
    logic w_have_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic [7:0] araddr_q;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire aw_hs = s_awvalid && s_awready;
    wire w_hs = s_wvalid && s_wready;
    wire wr_go = aw_have_q && w_have_q && !s_bvalid;
    wire b_hs = s_bvalid && s_bready;
    wire ar_hs = s_arvalid && s_arready;
    wire r_hs = s_rvalid && s_rready;

    function automatic logic mapped(input logic [7:0] addr);
        return addr == MODE_OFFSET || addr == STATUS_OFFSET || addr == MASK_OFFSET ||
               addr == CKE_OFFSET;
    endfunction

    wire [31:0] byte_mask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    wire wr_mode = wr_go && awaddr_q == MODE_OFFSET;
    wire wr_status = wr_go && awaddr_q == STATUS_OFFSET;
    wire wr_mask = wr_go && awaddr_q == MASK_OFFSET;
    wire [31:0] mode_bits = byte_mask & MODE_WR_MASK;
    wire [31:0] mode_d = (mode_q & ~mode_bits) | (wdata_q & mode_bits);
    wire [EV_WIDTH-1:0] clr_bits = wr_status ? (wdata_q[EV_WIDTH-1:0] & byte_mask[EV_WIDTH-1:0])
                                             : EV_RESET;

    wire [31:0] mode_rd = {2'b00, mode_q[29:0]};
    wire [31:0] rd_word = (araddr_q == MODE_OFFSET) ? mode_rd :
                          (araddr_q == STATUS_OFFSET) ? {{(32-EV_WIDTH){1'b0}}, status_q} :
                          (araddr_q == MASK_OFFSET) ? {{(32-EV_WIDTH){1'b0}}, mask_q} :
                          (araddr_q == CKE_OFFSET) ? {{(32-ROW_PAIRS){1'b0}}, cke} : ZERO_WORD;
    wire rd_go = ar_hs;

    // ------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_awready <= 1'b1;
            s_wready <= 1'b1;
            s_bvalid <= 1'b0;
            s_bresp <= RESP_OKAY;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= ZERO_WORD;
            wstrb_q <= 4'h0;
        end else if (ce) begin
            if (aw_hs) begin
                aw_have_q <= 1'b1;
                awaddr_q <= s_awaddr;
                s_awready <= 1'b0;
            end else if (wr_go) begin
                aw_have_q <= 1'b0;
            end else if (b_hs) begin
                s_awready <= 1'b1;
            end
            if (w_hs) begin
                w_have_q <= 1'b1;
                wdata_q <= s_wdata;
                wstrb_q <= s_wstrb;
                s_wready <= 1'b0;
            end else if (wr_go) begin
                w_have_q <= 1'b0;
            end else if (b_hs) begin
                s_wready <= 1'b1;
            end
            if (wr_go) begin
                s_bvalid <= 1'b1;
                s_bresp <= mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
            end else if (b_hs) begin
                s_bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    // The address is latched first so the data mux sees a stable index; this
    // costs one cycle of read latency but keeps rdata straight from a flop.
    logic rd_pend_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_arready <= 1'b1;
            s_rvalid <= 1'b0;
            s_rdata <= ZERO_WORD;
            s_rresp <= RESP_OKAY;
            araddr_q <= 8'h00;
            rd_pend_q <= 1'b0;
        end else if (ce) begin
            rd_pend_q <= rd_go;
            if (rd_go) begin
                araddr_q <= s_araddr;
                s_arready <= 1'b0;
            end
            if (rd_pend_q) begin
                s_rvalid <= 1'b1;
                s_rdata <= rd_word;
                s_rresp <= mapped(araddr_q) ? RESP_OKAY : RESP_SLVERR;
            end else if (r_hs) begin
                s_rvalid <= 1'b0;
                s_arready <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Mode register, status and mask
    // ------------------------------------------------------------
    logic [EV_WIDTH-1:0] ev_set;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_q <= MODE_RESET;
            status_q <= EV_RESET;
            mask_q <= EV_RESET;
            irq <= 1'b0;
        end else if (ce) begin
            if (wr_mode) begin
                mode_q <= mode_d;
            end
            if (wr_mask) begin
                mask_q <= wdata_q[EV_WIDTH-1:0];
            end
            // A set in the same cycle as its clear wins.
            status_q <= (status_q & ~clr_bits) | ev_set;
            irq <= |(((status_q & ~clr_bits) | ev_set) & mask_q);
        end
    end

    wire pd_en = mode_q[PD_BIT];
    wire retry_en = mode_q[RETRY_BIT];
    wire overlap_en = mode_q[OVERLAP_BIT];
    wire [1:0] wr_ap_code = mode_q[WR_AP_LSB+:2];
    wire [1:0] rd_ap_code = mode_q[RD_AP_LSB+:2];
    wire [1:0] integ_code = mode_q[INTEG_LSB+:2];

    // ------------------------------------------------------------
    // Row pair power-down
    // ------------------------------------------------------------
    logic [ROW_PAIRS-1:0] grant_vec;

    generate
        for (genvar p = 0; p < ROW_PAIRS; p++) begin : g_pair
            cke_pair_ctl #(
                .BANKS(BANKS)
            ) u_pair (
                .aclk(aclk),
                .aresetn(aresetn),
                .ce(ce),
                .pd_en(pd_en),
                .bank_open(bank_open[p*BANKS+:BANKS]),
                .req(acc_valid && acc_pair == PAIR_W'(p)),
                .cke_q(cke[p]),
                .grant_q(grant_vec[p])
            );
        end
    endgenerate

    assign acc_grant = |grant_vec;

    // ------------------------------------------------------------
    // ECC mode and error logging
    // ------------------------------------------------------------
    ecc_mode_ctl u_ecc (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .mode_code(integ_code),
        .single_channel(single_channel),
        .err_seen(rd_done && (rd_sbe || rd_ded)),
        .first_pending(status_q[EV_LOG]),
        .eff_mode_q(integ_mode),
        .corr_en_q(corr_en),
        .log_first_q(log_first),
        .log_next_q(log_next)
    );

    // ------------------------------------------------------------
    // Retry, overlap and auto-precharge policy
    // ------------------------------------------------------------
    // Double-bit errors are only seen while ECC checking is on.
    wire ded_seen = rd_done && rd_ded && corr_en;
    wire retry_d = ded_seen && retry_en && !rd_was_retry;
    wire fatal_d = ded_seen && !retry_d;
    wire [1:0] ap_code = col_is_write ? wr_ap_code : rd_ap_code;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            retry_req <= 1'b0;
            act_allowed <= 1'b0;
            ap_flag <= 1'b0;
            init_done_flag <= 1'b0;
        end else if (ce) begin
            retry_req <= retry_d;
            act_allowed <= overlap_en || !col_busy;
            ap_flag <= col_valid && ap_close(ap_code, row_hit_queued);
            init_done_flag <= mode_q[INIT_BIT];
        end
    end

    assign ev_set[EV_FATAL] = fatal_d;
    assign ev_set[EV_RETRY] = retry_d;
    assign ev_set[EV_LOG] = log_first || log_next;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_rev_zero;
        s_rvalid |-> s_rdata[31:30] == 2'b00 || s_rresp != RESP_OKAY || araddr_q != MODE_OFFSET;
    endproperty
    a_rev_zero: assert property (p_rev_zero) else $error("revision field not zero");

    property p_init_flag;
        ce && wr_mode && wstrb_q[3] ##1 ce |=> init_done_flag == $past(wdata_q[INIT_BIT], 2);
    endproperty
    a_init_flag: assert property (p_init_flag) else $error("init flag not stored");

    property p_pd_enter;
        ce && pd_en && !acc_valid && bank_open[BANKS-1:0] == '0 |=> !cke[0];
    endproperty
    a_pd_enter: assert property (p_pd_enter) else $error("idle pair not powered down");

    property p_wake;
        ce && acc_valid && acc_pair == '0 && !cke[0] |=> cke[0] && !acc_grant;
    endproperty
    a_wake: assert property (p_wake) else $error("pair not woken before access");

    property p_grant_awake;
        acc_grant |-> $past(cke[acc_pair]);
    endproperty
    a_grant_awake: assert property (p_grant_awake) else $error("grant while powered down");

    property p_retry;
        ce && rd_done && rd_ded && corr_en && retry_en && !rd_was_retry |=> retry_req;
    endproperty
    a_retry: assert property (p_retry) else $error("retry not issued");

    property p_no_retry;
        ce && (!retry_en || rd_was_retry) |=> !retry_req;
    endproperty
    a_no_retry: assert property (p_no_retry) else $error("unexpected retry");

    property p_overlap;
        ce && col_busy |=> act_allowed == $past(overlap_en);
    endproperty
    a_overlap: assert property (p_overlap) else $error("overlap policy broken");

    property p_ap_write;
        ce && col_valid && col_is_write && wr_ap_code == AP_ALWAYS |=> ap_flag;
    endproperty
    a_ap_write: assert property (p_ap_write) else $error("write auto-precharge missing");

    property p_ap_read;
        ce && col_valid && !col_is_write && rd_ap_code == AP_NEVER |=> !ap_flag;
    endproperty
    a_ap_read: assert property (p_ap_read) else $error("read auto-precharge not held off");

    property p_smart;
        ce && col_valid && ap_code == AP_SMART |=> ap_flag == !$past(row_hit_queued);
    endproperty
    a_smart: assert property (p_smart) else $error("smart precharge wrong");

    property p_nonecc;
        ce && integ_mode == INTEG_NONE && integ_code == INTEG_NONE |=> !log_first && !log_next;
    endproperty
    a_nonecc: assert property (p_nonecc) else $error("error logged without ECC");

    property p_fallback;
        ce && single_channel && integ_code == INTEG_CHIPFAIL |=> integ_mode == INTEG_ECC72;
    endproperty
    a_fallback: assert property (p_fallback) else $error("chip-fail kept in single channel");

    c_retry: cover property (ce && retry_req);
    c_wake: cover property (ce && acc_valid && !cke[acc_pair] ##2 acc_grant);
    c_irq: cover property (irq ##1 !irq);

endmodule

// File: test/dimm_pair_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Row pairs on the memory channel
// ------------------------------------------------------------
// An activate sent to a pair whose clock enable is low is lost.
// A real module ignores it too.
module dimm_pair_model #(
    parameter int ROW_PAIRS = 4,
    parameter int BANKS = 4
) (
    input wire logic aclk, // controller clock
    input wire logic aresetn, // synchronous reset, active low
    input wire logic [ROW_PAIRS-1:0] cke, // clock enable per pair
    input wire logic act_valid, // activate bank 0 of a pair
    input wire logic [1:0] act_pair, // pair of the activate
    input wire logic pre_all, // precharge every bank
    output logic [ROW_PAIRS*BANKS-1:0] bank_open, // open banks
    output logic act_lost_q // activate seen while powered down
);
    always_ff @(posedge aclk) begin
        if (!aresetn || pre_all) begin
            bank_open <= '0;
        end else if (act_valid && cke[act_pair]) begin
            bank_open[act_pair*BANKS] <= 1'b1;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            act_lost_q <= 1'b0;
        end else if (act_valid && !cke[act_pair]) begin
            act_lost_q <= 1'b1;
        end
    end
endmodule

// File: test/dram_mode_ctl_test.sv
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module dram_mode_ctl_test;
    import dram_mode_pkg::*;
    logic aclk, aresetn, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    logic s_arvalid, s_arready, s_rvalid, s_rready, irq, acc_valid, acc_grant, rd_done;
    logic single_channel, rd_ded, rd_was_retry, retry_req, corr_en, log_first, log_next;
    logic col_busy, act_allowed, col_valid, col_is_write, row_hit_queued, ap_flag;
    logic init_done_flag, act_valid, pre_all, act_lost;
    logic [7:0] s_awaddr, s_araddr;
    logic [31:0] s_wdata, s_rdata, rd;
    logic [1:0] s_bresp, s_rresp, rsp, acc_pair, act_pair, c;
    logic [15:0] bank_open;
    logic [3:0] cke;
    integ_mode_type integ_mode;
    int n_errors = 0;
    int cmp_count = 0;
    // ------------------------------------------------------------
    // Design and partner
    // ------------------------------------------------------------
    dram_mode_ctl dram_mode_ctl_i (.aclk, .aresetn, .ce(1'b1), .s_awaddr, .s_awvalid,
        .s_awready, .s_wdata, .s_wstrb(4'hF), .s_wvalid, .s_wready, .s_bresp, .s_bvalid,
        .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid,
        .s_rready, .irq, .bank_open, .acc_valid, .acc_pair, .cke, .acc_grant,
        .single_channel, .rd_done, .rd_sbe(1'b0), .rd_ded, .rd_was_retry, .retry_req,
        .corr_en, .integ_mode, .log_first, .log_next, .col_busy, .act_allowed, .col_valid,
        .col_is_write, .row_hit_queued, .ap_flag, .init_done_flag);
    dimm_pair_model dimm_pair_model_i (.aclk, .aresetn, .cke, .act_valid, .act_pair,
        .pre_all, .bank_open, .act_lost_q(act_lost));
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    // Handshakes are judged at the falling edge, where every signal is settled.
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ha, hw, hb;
        @(posedge aclk);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        hb = 1'b0;
        while (!hb) begin
            @(negedge aclk);
            ha = s_awvalid & s_awready;
            hw = s_wvalid & s_wready;
            hb = s_bvalid;
            r = s_bresp;
            @(posedge aclk);
            if (ha) s_awvalid <= 1'b0;
            if (hw) s_wvalid <= 1'b0;
        end
        s_bready <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        axw(a, d, rsp);
        `CHK(rsp, RESP_OKAY)
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic ha, hr;
        @(posedge aclk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        hr = 1'b0;
        while (!hr) begin
            @(negedge aclk);
            ha = s_arvalid & s_arready;
            hr = s_rvalid;
            rd = s_rdata;
            rsp = s_rresp;
            @(posedge aclk);
            if (ha) s_arvalid <= 1'b0;
        end
        s_rready <= 1'b0;
        `CHK(rd, e)
        `CHK(rsp, er)
    endtask
    task automatic rdev(input logic d, w, er, ef, en);
        @(posedge aclk);
        rd_done <= 1'b1;
        rd_ded <= d;
        rd_was_retry <= w;
        @(posedge aclk);
        rd_done <= 1'b0;
        @(negedge aclk);
        `CHK({retry_req, log_first, log_next}, {er, ef, en})
    endtask
    task automatic colev(input logic w, h, e);
        @(posedge aclk);
        col_valid <= 1'b1;
        col_is_write <= w;
        row_hit_queued <= h;
        @(posedge aclk);
        col_valid <= 1'b0;
        @(negedge aclk);
        `CHK(ap_flag, e)
    endtask
    // The request is held one cycle past the grant so the activate lands while awake.
    task automatic acc(input logic [1:0] p, input logic o, input int ex);
        int n;
        @(posedge aclk);
        acc_valid <= 1'b1;
        acc_pair <= p;
        n = 0;
        while (acc_grant !== 1'b1 && n < 9) begin
            @(negedge aclk);
            n++;
        end
        `CHK(cke[p], 1'b1)
        `CHK(n, ex)
        @(posedge aclk);
        act_valid <= o;
        act_pair <= p;
        @(posedge aclk);
        acc_valid <= 1'b0;
        act_valid <= 1'b0;
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        {aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, acc_valid} = '0;
        {rd_done, single_channel, rd_ded, rd_was_retry, col_busy, col_valid} = '0;
        {col_is_write, row_hit_queued, act_valid, pre_all, s_awaddr, s_araddr} = '0;
        {s_wdata, acc_pair, act_pair} = '0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        `CHK(cke, 4'hF)
        rdchk(MODE_OFFSET, MODE_RESET, RESP_OKAY);
        wr(MODE_OFFSET, 32'hFFFFFFFF);
        rdchk(MODE_OFFSET, MODE_WR_MASK, RESP_OKAY);
        `CHK(init_done_flag, 1'b1)
        rdchk(8'h40, ZERO_WORD, RESP_SLVERR);
        axw(8'h40, 32'hFFFFFFFF, rsp);
        `CHK(rsp, RESP_SLVERR)
        $display("test registers done");
        col_busy <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            c = i[1:0];
            wr(MODE_OFFSET, {5'h00, c[0], c, c, c, 20'h00008});
            @(posedge aclk);
            @(negedge aclk);
            `CHK(integ_mode, (c == 2'h3) ? INTEG_NONE : integ_mode_type'(c))
            `CHK(corr_en, c == 2'h1 || c == 2'h2)
            `CHK(act_allowed, c[0])
            `CHK(init_done_flag, 1'b0)
            if (c == 2'h0) rdev(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
            for (int j = 0; j < 4; j++) colev(j[0], j[1], c == 1 || (c == 0 && !j[1]));
        end
        @(posedge aclk);
        single_channel <= 1'b1;
        wr(MODE_OFFSET, 32'h00200008);
        @(posedge aclk);
        @(negedge aclk);
        `CHK(integ_mode, INTEG_ECC72)
        @(posedge aclk);
        single_channel <= 1'b0;
        $display("test modes done");
        wr(MASK_OFFSET, 32'h00000007);
        wr(MODE_OFFSET, 32'h08100008);
        rdev(1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
        rdev(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
        rdchk(STATUS_OFFSET, 32'h00000007, RESP_OKAY);
        `CHK(irq, 1'b1)
        wr(STATUS_OFFSET, 32'h00000007);
        rdchk(STATUS_OFFSET, ZERO_WORD, RESP_OKAY);
        `CHK(irq, 1'b0)
        wr(MASK_OFFSET, ZERO_WORD);
        wr(MODE_OFFSET, 32'h00100008);
        rdev(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
        rdchk(STATUS_OFFSET, 32'h00000005, RESP_OKAY);
        `CHK(irq, 1'b0)
        $display("test retry done");
        wr(MODE_OFFSET, 32'h10000008);
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        `CHK(cke, 4'h0)
        acc(2'h0, 1'b1, 3);
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        `CHK(cke, 4'h1)
        pre_all <= 1'b1;
        @(posedge aclk);
        pre_all <= 1'b0;
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        `CHK(cke, 4'h0)
        `CHK(act_lost, 1'b0)
        wr(MODE_OFFSET, MODE_RESET);
        @(negedge aclk);
        `CHK(cke, 4'hF)
        acc(2'h1, 1'b0, 2);
        $display("test power-down done");
        finish_test;
    end
    initial begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        finish_test;
    end
endmodule
